// *** src/timer_set_pkg.sv ***
`default_nettype none
package timer_set_pkg;
  // count source codes for the classic pair
  localparam logic [2:0] SRC_SYS = 3'h0;
  localparam logic [2:0] SRC_DIV12 = 3'h1;
  localparam logic [2:0] SRC_DIV4 = 3'h2;
  localparam logic [2:0] SRC_DIV48 = 3'h3;
  localparam logic [2:0] SRC_EXT8 = 3'h4;
  localparam logic [2:0] SRC_PIN = 3'h5;
  localparam logic [2:0] SRC_LFO8 = 3'h6;
  localparam int DIV12_CNT = 12;
  localparam int DIV4_CNT = 4;
  localparam int DIV48_CNT = 48;
  localparam int EXT_DIV = 8;
  localparam int LFO_DIV = 8;
  localparam logic [15:0] COUNT_RST = 16'h0000;
  localparam logic [12:0] MODE1_MAX = 13'h1FFF;
  localparam logic [7:0] BYTE_MAX = 8'hFF;
  localparam logic [15:0] WORD_MAX = 16'hFFFF;
  // capture source codes for timers 2..4
  localparam logic [1:0] CAP_PIN = 2'h0;
  localparam logic [1:0] CAP_LFO = 2'h1;
  localparam logic [1:0] CAP_CMP0 = 2'h2;
  localparam logic [1:0] CAP_SOF = 2'h3;
  typedef enum logic [1:0] {
    MODE_13BIT = 2'b00,
    MODE_16BIT = 2'b01,
    MODE_RELOAD8 = 2'b10,
    MODE_DUAL8 = 2'b11
  } classic_mode_t;
endpackage
`default_nettype wire

// *** src/tick_if.sv ***
`default_nettype none
interface tick_if;
  logic sys;
  logic div12;
  logic div4;
  logic div48;
  logic ext8;
  logic lfo8;
  logic pin_t0;
  logic pin_t1;
  modport gen (output sys, div12, div4, div48, ext8, lfo8, pin_t0, pin_t1);
  modport use_side (input sys, div12, div4, div48, ext8, lfo8, pin_t0, pin_t1);
endinterface
`default_nettype wire

// *** src/tick_gen.sv ***
`default_nettype none
module tick_gen
  import timer_set_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic ext_clk_i,
  input wire logic lfo_clk_i,
  input wire logic pin_t0_i,
  input wire logic pin_t1_i,
  tick_if.gen tk
);
  logic [5:0] c12_q, c4_q, c48_q;
  logic [2:0] e_q, l_q;
  logic ext_q, lfo_q, p0_q, p1_q;
  wire ext_rise = ext_clk_i & ~ext_q;
  wire lfo_rise = lfo_clk_i & ~lfo_q;
  assign tk.sys = 1'b1;
  assign tk.div12 = (c12_q == 6'(DIV12_CNT - 1));
  assign tk.div4 = (c4_q == 6'(DIV4_CNT - 1));
  assign tk.div48 = (c48_q == 6'(DIV48_CNT - 1));
  assign tk.ext8 = ext_rise & (e_q == 3'(EXT_DIV - 1));
  assign tk.lfo8 = lfo_rise & (l_q == 3'(LFO_DIV - 1));
  // pin counts on falling transition, as the classic pair does
  assign tk.pin_t0 = p0_q & ~pin_t0_i;
  assign tk.pin_t1 = p1_q & ~pin_t1_i;
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      c12_q <= 6'h00; c4_q <= 6'h00; c48_q <= 6'h00; e_q <= 3'h0; l_q <= 3'h0;
      ext_q <= 1'b0; lfo_q <= 1'b0; p0_q <= 1'b0; p1_q <= 1'b0;
    end else begin
      c12_q <= tk.div12 ? 6'h00 : c12_q + 6'h01;
      c4_q <= tk.div4 ? 6'h00 : c4_q + 6'h01;
      c48_q <= tk.div48 ? 6'h00 : c48_q + 6'h01;
      if (ext_rise) e_q <= e_q + 3'h1;
      if (lfo_rise) l_q <= l_q + 3'h1;
      ext_q <= ext_clk_i; lfo_q <= lfo_clk_i; p0_q <= pin_t0_i; p1_q <= pin_t1_i;
    end
  end
endmodule
`default_nettype wire

// *** src/timer_set.sv ***
// Contract
// - five timers, two classic 16-bit ones
// - overflow raises a periodic request flag
// - four modes per classic timer
// - classic source: clock, /12, /4, /48, ext/8, pin; the code also lets them count low-freq /8
// - reload 8-bit, 13-bit and 16-bit modes
// - dual 8-bit only on timer 0
// - timers 2-4 clock, /12 or ext/8; the code also lets them count /4 and /48
// - timers 3,4 may count low-freq /8
// - timer 4 event drives wake output
// - timer 4 chains from timer 3
// - timers 2-4 16-bit auto reload
// - timers 2-4 split 8-bit reload
// - capture on pin, lfo, cmp0, sof
`default_nettype none
module timer_set
  import timer_set_pkg::*;
(
  input wire logic clock_i,
  input wire logic srst_i,
  input wire logic ext_clk_i,
  input wire logic lfo_clk_i,
  input wire logic pin_t0_i,
  input wire logic pin_t1_i,
  input wire logic [1:0] run_c_i,
  input wire logic run_t0_hi_i,
  input wire logic [1:0][1:0] mode_c_i,
  input wire logic [1:0][2:0] src_c_i,
  input wire logic [1:0] load_c_i,
  input wire logic [1:0][15:0] load_val_c_i,
  input wire logic [2:0] run_n_i,
  input wire logic [2:0] split_n_i,
  input wire logic [2:0][2:0] src_n_i,
  input wire logic [2:0][15:0] reload_n_i,
  input wire logic [2:0] load_n_i,
  input wire logic [2:0] cap_en_n_i,
  input wire logic [2:0][1:0] cap_sel_n_i,
  input wire logic [2:0] cap_pin_i,
  input wire logic cmp0_i,
  input wire logic sof_i,
  input wire logic chain_i,
  input wire logic [5:0] flag_clr_i,
  output logic [1:0][15:0] count_c_o,
  output logic [2:0][15:0] count_n_o,
  output logic [2:0][15:0] capture_n_o,
  output logic [5:0] ovf_flag_o,
  output logic [2:0] low_flag_o,
  output logic [2:0] cap_flag_o,
  output logic wake_o
);
  tick_if tk();
  tick_gen u_tick (
    .clock_i(clock_i), .srst_i(srst_i), .ext_clk_i(ext_clk_i), .lfo_clk_i(lfo_clk_i),
    .pin_t0_i(pin_t0_i), .pin_t1_i(pin_t1_i), .tk(tk)
  );
  function automatic logic pick(input logic [2:0] s, input logic pin);
    unique case (s)
      SRC_SYS: pick = tk.sys;
      SRC_DIV12: pick = tk.div12;
      SRC_DIV4: pick = tk.div4;
      SRC_DIV48: pick = tk.div48;
      SRC_EXT8: pick = tk.ext8;
      SRC_PIN: pick = pin;
      SRC_LFO8: pick = tk.lfo8;
      default: pick = 1'b0;
    endcase
  endfunction
  // flags: ovf bits 0,1 classic, bit 2 classic t0 high byte, 3..5 timers 2..4
  logic [1:0][15:0] cc_q, cc_d;
  logic [2:0][15:0] nc_q, nc_d, cap_q;
  logic [5:0] ovf_q, ovf_set;
  logic [2:0] low_q, low_set, cap_f_q, cap_set;
  logic [2:0] lfo_q;
  logic [2:0] lfo_rise_n;
  logic [2:0][3:0] cap_v;
  genvar g;
  generate
    for (g = 0; g < 2; g++) begin : g_classic
      wire tick = run_c_i[g] & pick(src_c_i[g], g == 0 ? tk.pin_t0 : tk.pin_t1);
      wire dual = (g == 0) && (mode_c_i[g] == MODE_DUAL8);
      wire [12:0] c13 = {cc_q[g][15:8], cc_q[g][4:0]};
      logic [15:0] nx;
      logic ov;
      always_comb begin
        nx = cc_q[g];
        ov = 1'b0;
        if (tick) begin
          unique case (mode_c_i[g])
            MODE_13BIT: begin
              ov = (c13 == MODE1_MAX);
              nx = {cc_q[g][15:8] + {7'h00, cc_q[g][4:0] == 5'h1F}, cc_q[g][7:5],
                    cc_q[g][4:0] + 5'h01};
            end
            MODE_16BIT: begin
              ov = (cc_q[g] == WORD_MAX);
              nx = cc_q[g] + 16'h0001;
            end
            MODE_RELOAD8: begin
              ov = (cc_q[g][7:0] == BYTE_MAX);
              nx = {cc_q[g][15:8], ov ? cc_q[g][15:8] : cc_q[g][7:0] + 8'h01};
            end
            MODE_DUAL8: begin
              // timer 1 holds in this mode
              ov = (g == 0) && (cc_q[g][7:0] == BYTE_MAX);
              nx = (g == 0) ? {cc_q[g][15:8], cc_q[g][7:0] + 8'h01} : cc_q[g];
            end
          endcase
        end
        // high byte counts the system clock /12 on its own run bit
        if (dual && run_t0_hi_i && tk.div12) nx[15:8] = cc_q[g][15:8] + 8'h01;
        if (load_c_i[g]) nx = load_val_c_i[g];
      end
      assign cc_d[g] = nx;
      assign ovf_set[g] = ov;
    end
    for (g = 0; g < 3; g++) begin : g_new
      // only timers 3 and 4 may use the slow source
      wire [2:0] s = (g == 0 && src_n_i[g] == SRC_LFO8) ? SRC_SYS : src_n_i[g];
      wire base = pick(s, 1'b0);
      // timer 4 steps on timer 3 overflow when chained
      wire tick = run_n_i[g] & ((g == 2 && chain_i) ? ovf_set[4] : base);
      wire lo_ov = tick & (nc_q[g][7:0] == BYTE_MAX);
      wire hi_ov = tick & (nc_q[g][15:8] == BYTE_MAX);
      wire w_ov = tick & (nc_q[g] == WORD_MAX);
      logic [15:0] nx;
      always_comb begin
        nx = nc_q[g];
        if (tick && split_n_i[g]) begin
          // each half reloads from its own byte
          nx[7:0] = lo_ov ? reload_n_i[g][7:0] : nc_q[g][7:0] + 8'h01;
          nx[15:8] = hi_ov ? reload_n_i[g][15:8] : nc_q[g][15:8] + 8'h01;
        end else if (tick) begin
          nx = w_ov ? reload_n_i[g] : nc_q[g] + 16'h0001;
        end
        if (load_n_i[g]) nx = reload_n_i[g];
      end
      assign nc_d[g] = nx;
      assign ovf_set[g + 3] = split_n_i[g] ? hi_ov : w_ov;
      assign low_set[g] = split_n_i[g] & lo_ov;
      assign lfo_rise_n[g] = tk.lfo8;
      assign cap_v[g] = {sof_i, cmp0_i, lfo_rise_n[g], cap_pin_i[g] & ~lfo_q[g]};
      assign cap_set[g] = cap_en_n_i[g] & cap_v[g][cap_sel_n_i[g]];
    end
  endgenerate
  assign ovf_set[2] = (mode_c_i[0] == MODE_DUAL8) & run_t0_hi_i & tk.div12 &
                      (cc_q[0][15:8] == BYTE_MAX);
  always_ff @(posedge clock_i) begin
    if (srst_i) begin
      cc_q <= '0; nc_q <= '0; cap_q <= '0;
      ovf_q <= 6'h00; low_q <= 3'h0; cap_f_q <= 3'h0; lfo_q <= 3'h0;
    end else begin
      cc_q <= cc_d;
      nc_q <= nc_d;
      lfo_q <= cap_pin_i;
      for (int i = 0; i < 3; i++) begin
        if (cap_set[i]) cap_q[i] <= nc_q[i];
      end
      ovf_q <= (ovf_q & ~flag_clr_i) | ovf_set;
      low_q <= (low_q & ~flag_clr_i[5:3]) | low_set;
      cap_f_q <= (cap_f_q & ~flag_clr_i[5:3]) | cap_set;
    end
  end
  assign count_c_o = cc_q;
  assign count_n_o = nc_q;
  assign capture_n_o = cap_q;
  assign ovf_flag_o = ovf_q;
  assign low_flag_o = low_q;
  assign cap_flag_o = cap_f_q;
  // wake while timer 4 event pending
  assign wake_o = ovf_q[5] | cap_f_q[2];

  a_flag_sticky: assert property (@(posedge clock_i) disable iff (srst_i)
    ovf_set[3] |=> ovf_flag_o[3]) else $error("overflow flag not set");
  a_word_reload: assert property (@(posedge clock_i) disable iff (srst_i)
    (ovf_set[3] && !split_n_i[0] && !load_n_i[0]) |=> count_n_o[0] == $past(reload_n_i[0]))
    else $error("reload missed");
  a_wake_follows: assert property (@(posedge clock_i) disable iff (srst_i)
    ovf_set[5] |=> wake_o) else $error("no wake");
  a_chain_step: assert property (@(posedge clock_i) disable iff (srst_i)
    (chain_i && run_n_i[2] && !ovf_set[4] && !load_n_i[2]) |=> $stable(count_n_o[2]))
    else $error("chain stepped");
  a_mode_16: assert property (@(posedge clock_i) disable iff (srst_i)
    (run_c_i[1] && mode_c_i[1] == MODE_16BIT && src_c_i[1] == SRC_SYS && !load_c_i[1])
    |=> count_c_o[1] == $past(count_c_o[1]) + 16'h0001) else $error("16-bit step");
  a_t1_dual_hold: assert property (@(posedge clock_i) disable iff (srst_i)
    (mode_c_i[1] == MODE_DUAL8 && !load_c_i[1]) |=> $stable(count_c_o[1]))
    else $error("timer 1 moved");
  a_cap_take: assert property (@(posedge clock_i) disable iff (srst_i)
    cap_set[1] |=> capture_n_o[1] == $past(count_n_o[1])) else $error("capture");
  a_split_low: assert property (@(posedge clock_i) disable iff (srst_i)
    (low_set[0] && !load_n_i[0]) |=> count_n_o[0][7:0] == $past(reload_n_i[0][7:0]))
    else $error("low reload");
  a_split_high: assert property (@(posedge clock_i) disable iff (srst_i)
    (ovf_set[4] && split_n_i[1] && !load_n_i[1])
    |=> count_n_o[1][15:8] == $past(reload_n_i[1][15:8])) else $error("high reload");
  a_byte_reload: assert property (@(posedge clock_i) disable iff (srst_i)
    (ovf_set[0] && mode_c_i[0] == MODE_RELOAD8 && !load_c_i[0])
    |=> count_c_o[0][7:0] == $past(count_c_o[0][15:8])) else $error("8-bit reload");
  a_t0_hi_wrap: assert property (@(posedge clock_i) disable iff (srst_i)
    (ovf_set[2] && !load_c_i[0]) |=> count_c_o[0][15:8] == 8'h00)
    else $error("high byte wrap");
  a_cap_flag: assert property (@(posedge clock_i) disable iff (srst_i)
    cap_set[2] |=> cap_flag_o[2] && wake_o) else $error("capture flag");
endmodule
`default_nettype wire

// *** verif/timer_set_tb.sv ***
`default_nettype none
module timer_set_tb
  import timer_set_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic clock_i = 0, srst_i = 1, ext_clk_i = 0, lfo_clk_i = 0, pin_t0_i = 0, pin_t1_i = 0;
  logic [1:0] run_c_i = '0, load_c_i = '0;
  logic run_t0_hi_i = 0, cmp0_i = 0, sof_i = 0, chain_i = 0;
  logic [1:0][1:0] mode_c_i = '0;
  logic [1:0][2:0] src_c_i = '0;
  logic [1:0][15:0] load_val_c_i = '0;
  logic [2:0] run_n_i = '0, split_n_i = '0, load_n_i = '0, cap_en_n_i = '0, cap_pin_i = '0;
  logic [2:0][2:0] src_n_i = '0;
  logic [2:0][15:0] reload_n_i = '0;
  logic [2:0][1:0] cap_sel_n_i = '0;
  logic [5:0] flag_clr_i = '0;
  logic [1:0][15:0] count_c_o;
  logic [2:0][15:0] count_n_o, capture_n_o;
  logic [5:0] ovf_flag_o;
  logic [2:0] low_flag_o, cap_flag_o;
  logic wake_o;
  logic [15:0] r;
  int checked = 0, fails = 0, cycles = 0;
  int dv[6] = '{1, 4, 12, 48, 16, 16};
  logic [2:0] sr[6] = '{SRC_SYS, SRC_DIV4, SRC_DIV12, SRC_DIV48, SRC_EXT8, SRC_LFO8};
  timer_set DUT (.clock_i, .srst_i, .ext_clk_i, .lfo_clk_i, .pin_t0_i, .pin_t1_i, .run_c_i,
    .run_t0_hi_i, .mode_c_i, .src_c_i, .load_c_i, .load_val_c_i, .run_n_i, .split_n_i,
    .src_n_i, .reload_n_i, .load_n_i, .cap_en_n_i, .cap_sel_n_i, .cap_pin_i, .cmp0_i,
    .sof_i, .chain_i, .flag_clr_i, .count_c_o, .count_n_o, .capture_n_o, .ovf_flag_o,
    .low_flag_o, .cap_flag_o, .wake_o);
  always #25 clock_i = ~clock_i;
  // both slow sources rise every second clock, so each /8 tick comes every 16 clocks
  always @(negedge clock_i) begin
    ext_clk_i <= ~ext_clk_i;
    lfo_clk_i <= ~lfo_clk_i;
  end
  always @(posedge clock_i) begin
    cycles++;
    if (cycles > 20000) begin
      fails++;
      end_of_test();
    end
  end
  function automatic logic [15:0] reload8(input logic [15:0] v);
    return {v[15:8], v[15:8]};
  endfunction
  task automatic cyc(input int n);
    repeat (n) @(negedge clock_i);
  endtask
  task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
    checked++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_of_test();
    $display("checked=%0d fails=%0d", checked, fails);
    if (fails == 0 && checked > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  task automatic load_c(input int t, input logic [15:0] v);
    load_val_c_i[t] = v;
    load_c_i[t] = 1;
    cyc(1);
    load_c_i[t] = 0;
  endtask
  task automatic pulse_run(input int t, input int n);
    run_c_i[t] = 1;
    cyc(n);
    run_c_i[t] = 0;
  endtask
  initial begin
    void'($urandom(84147));
    cyc(16);
    srst_i = 0;
    cmp({3'h0, ovf_flag_o, low_flag_o, cap_flag_o, wake_o}, 16'h0000);
    for (int t = 0; t < 2; t++) begin
      mode_c_i[t] = MODE_16BIT;
      load_c(t, WORD_MAX);
      pulse_run(t, 1);
      cmp(count_c_o[t], COUNT_RST);
      cmp(16'(ovf_flag_o[t]), 16'h0001);
      flag_clr_i[t] = 1;
      cyc(1);
      flag_clr_i[t] = 0;
      cmp(16'(ovf_flag_o[t]), 16'h0000);
      mode_c_i[t] = MODE_13BIT;
      load_c(t, 16'hFF1F);
      pulse_run(t, 1);
      cmp(count_c_o[t], COUNT_RST);
      cmp(16'(ovf_flag_o[t]), 16'h0001);
      mode_c_i[t] = MODE_RELOAD8;
      r = 16'($urandom);
      load_c(t, {r[15:8], BYTE_MAX});
      pulse_run(t, 1);
      cmp(count_c_o[t], reload8(r));
      mode_c_i[t] = MODE_16BIT;
      for (int k = 0; k < 5; k++) begin
        src_c_i[t] = sr[k];
        load_c(t, COUNT_RST);
        pulse_run(t, dv[k] * 10);
        cmp(16'(count_c_o[t] >= 9 && count_c_o[t] <= 11), 16'h0001);
      end
      src_c_i[t] = SRC_PIN;
      load_c(t, COUNT_RST);
      run_c_i[t] = 1;
      repeat (5) begin
        {pin_t0_i, pin_t1_i} = 2'b11;
        cyc(3);
        {pin_t0_i, pin_t1_i} = 2'b00;
        cyc(3);
      end
      run_c_i[t] = 0;
      cmp(count_c_o[t], 16'h0005);
      src_c_i[t] = SRC_SYS;
    end
    mode_c_i = {MODE_DUAL8, MODE_DUAL8};
    load_c(0, 16'h00FF);
    load_c(1, 16'h1234);
    run_c_i = 2'b11;
    cyc(1);
    run_c_i = 2'b00;
    cmp(count_c_o[0], 16'h0000);
    cmp(count_c_o[1], 16'h1234);
    load_c(0, 16'hFF00);
    run_t0_hi_i = 1;
    cyc(12);
    run_t0_hi_i = 0;
    cmp(count_c_o[0], COUNT_RST);
    cmp(16'(ovf_flag_o[2]), 16'h0001);
    $display("classic timers done");
    for (int i = 0; i < 3; i++) begin
      src_n_i[i] = SRC_SYS;
      for (int s = 0; s < 2; s++) begin
        split_n_i[i] = s[0];
        reload_n_i[i] = s ? WORD_MAX : 16'hFFFE;
        load_n_i[i] = 1;
        cyc(1);
        load_n_i[i] = 0;
        r = 16'($urandom) & 16'hFFFD;
        reload_n_i[i] = r;
        run_n_i[i] = 1;
        cyc(2 - s);
        run_n_i[i] = 0;
        cmp(count_n_o[i], r);
        cmp({14'h0, ovf_flag_o[3 + i], low_flag_o[i]}, {14'h0, 1'b1, s[0]});
        if (i == 2) cmp(16'(wake_o), 16'h0001);
        flag_clr_i[3 + i] = 1;
        cyc(1);
        flag_clr_i[3 + i] = 0;
      end
      cap_en_n_i[i] = 1;
      for (int c = 0; c < 4; c++) begin
        begin
          cap_sel_n_i[i] = c[1:0];
          reload_n_i[i] = 16'($urandom);
          load_n_i[i] = 1;
          cyc(1);
          load_n_i[i] = 0;
          {cmp0_i, sof_i, cap_pin_i[i]} = {c == 2, c == 3, c == 0};
          cyc(1);
          {cmp0_i, sof_i, cap_pin_i[i]} = 3'b000;
          cyc(c == 1 ? 17 : 2);
          cmp(capture_n_o[i], reload_n_i[i]);
          cmp(16'(cap_flag_o[i]), 16'h0001);
          flag_clr_i[3 + i] = 1;
          cyc(1);
          flag_clr_i[3 + i] = 0;
        end
      end
      cap_en_n_i[i] = 0;
      split_n_i[i] = 0;
      reload_n_i[i] = COUNT_RST;
      for (int k = 0; k < 6; k++) begin
        if (k != 1 && k != 3 && !(k == 5 && i == 0)) begin
          src_n_i[i] = sr[k];
          load_n_i[i] = 1;
          cyc(1);
          load_n_i[i] = 0;
          run_n_i[i] = 1;
          cyc(dv[k] * 10);
          run_n_i[i] = 0;
          cmp(16'(count_n_o[i] >= 9 && count_n_o[i] <= 11), 16'h0001);
        end
      end
    end
    reload_n_i[1] = 16'hFFFE;
    reload_n_i[2] = COUNT_RST;
    src_n_i[1] = SRC_SYS;
    load_n_i = 3'h6;
    cyc(1);
    load_n_i = 3'h0;
    chain_i = 1;
    run_n_i = 3'h6;
    cyc(10);
    run_n_i = 3'h0;
    chain_i = 0;
    cmp(count_n_o[2], 16'h0005);
    cmp(count_n_o[1], 16'hFFFE);
    $display("reload timers done");
    end_of_test();
  end
endmodule
`default_nettype wire
